/* design/eeprom_map.svh */
// Timing counts, field positions and fixed values of the two-wire EEPROM read path
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define GLITCH_NS       50
// Cycles a new level must persist beyond the first sample
`define GLITCH_CYC      ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_IDLE_CYC    16
`define SCL_QTR_CYC     4

// ---------------------------------------------------------------
// Fields
// ---------------------------------------------------------------
`define BYTE_MSB        7
`define BIT_ACK         8
`define ADDR_MAX_W      9
`define RW_READ         1'b1
`define RW_WRITE        1'b0
`define ACK_LOW         1'b0
`define QTR_LAST        2'h3

`endif

/* design/eeprom_pkg.sv */
// Types shared by both ends of the two-wire EEPROM read path
package eeprom_pkg;

  // ---------------------------------------------------------------
  // Device end
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE    = 3'b000,
    D_DEVADDR = 3'b001,
    D_ACKDA   = 3'b010,
    D_MEMADDR = 3'b011,
    D_ACKMA   = 3'b100,
    D_TX      = 3'b101,
    D_RXACK   = 3'b110,
    D_WAIT    = 3'b111
  } dev_state_t;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       sda_s1;
    logic       sda_s2;
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
    logic       scl_f;
    logic       sda_f;
    logic [3:0] scl_cnt;
    logic [3:0] sda_cnt;
    logic [7:0] por_cnt;
    logic       por_done;
    dev_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [8:0] addr;
    logic       a8_p;
    logic       rw;
    logic       oe_n;
    logic       dout;
    logic       busy;
  } dev_regs_t;

  // ---------------------------------------------------------------
  // Master end
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE   = 3'b000,
    M_START  = 3'b001,
    M_DEV_W  = 3'b010,
    M_MADDR  = 3'b011,
    M_RSTART = 3'b100,
    M_DEV_R  = 3'b101,
    M_READ   = 3'b110,
    M_STOP   = 3'b111
  } mst_state_t;

  typedef struct packed {
    logic       sda_s1;
    logic       sda_s2;
    mst_state_t st;
    logic [1:0] q;
    logic [2:0] tick;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] left;
    logic [8:0] maddr;
    logic [2:0] sel;
    logic       scl;
    logic       oe_n;
    logic       dout;
    logic [7:0] rdd;
    logic       rdv;
    logic       busy;
    logic       nack;
  } mst_regs_t;

endpackage : eeprom_pkg

/* design/eeprom_link_if.sv */
// Two-wire link between the bus master and the EEPROM read end
`timescale 1ns/1ps
`default_nettype none

interface eeprom_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // ---------------------------------------------------------------
  // Open-drain wired AND, pulled high when nobody drives
  // ---------------------------------------------------------------
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe_n,
    input  sda
  );

  modport device (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe_n
  );
endinterface : eeprom_link_if

`default_nettype wire

/* design/eeprom_read_master.sv */
// Two-wire bus master issuing current-address, random and sequential reads
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"

module eeprom_read_master
  import eeprom_pkg::*;
#(
  parameter int         ADDR_W   = 8,
  parameter logic [3:0] DEV_TYPE = 4'h5  // Arbitrary type code
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  eeprom_link_if.host     link,
  input  wire logic       go,
  input  wire logic       random,
  input  wire logic [2:0] chip_sel,
  input  wire logic [8:0] mem_addr,
  input  wire logic [7:0] nbytes,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  output logic            busy,
  output logic            nack
);

  if (ADDR_W != 8 && ADDR_W != 9) begin : g_bad_w
    $error("ADDR_W must be 8 or 9");
  end

  mst_regs_t s;
  mst_regs_t n;
  logic      bit_end;
  logic      drv;
  logic [2:0] sel_w;

  always_comb begin
    n       = s;
    drv     = s.oe_n;
    n.rdv   = 1'b0;
    n.sda_s1 = link.sda;
    n.sda_s2 = s.sda_s1;
    sel_w   = (ADDR_W == 9) ? {s.sel[2:1], s.maddr[8]} : s.sel;
    bit_end = (s.tick == 3'(`SCL_QTR_CYC - 1)) && (s.q == `QTR_LAST);
    // ---------------------------------------------------------------
    // Quarter timing
    // ---------------------------------------------------------------
    if (s.st != M_IDLE) begin
      n.tick = s.tick + 3'h1;
      if (s.tick == 3'(`SCL_QTR_CYC - 1)) begin
        n.tick = 3'h0;
        n.q    = s.q + 2'h1;
      end
    end
    // ---------------------------------------------------------------
    // Line drive per quarter; data bits change only while clock is low, start and stop change sda while it is high
    // ---------------------------------------------------------------
    n.scl = s.q[1] | (s.st == M_IDLE);
    unique case (s.st)
      M_IDLE:  drv = 1'b1;
      M_START, M_RSTART: if (s.q != 2'h0) drv = (s.q != `QTR_LAST);
      M_STOP:  if (s.q != 2'h0) drv = (s.q == `QTR_LAST);
      M_READ: begin
        if (s.q != 2'h0) begin
          // RULE7 nack on last byte
          drv = (s.bitc != 4'(`BIT_ACK)) || (s.left == 8'h01);
        end
      end
      default: if (s.q != 2'h0) drv = (s.bitc == 4'(`BIT_ACK)) || s.sh[`BYTE_MSB];
    endcase
    n.oe_n = drv;
    // ---------------------------------------------------------------
    // Sequencing
    // ---------------------------------------------------------------
    if (s.st == M_IDLE) begin
      if (go) begin
        n.busy  = 1'b1;
        n.nack  = 1'b0;
        n.st    = M_START;
        n.q     = 2'h0;
        n.tick  = 3'h0;
        n.sel   = chip_sel;
        n.maddr = mem_addr;
        n.left  = nbytes;
        n.bitc  = 4'h0;
        // RULE1 dummy write first
        n.sh    = {DEV_TYPE, (ADDR_W == 9) ? {chip_sel[2:1], mem_addr[8]} : chip_sel,
                   random ? `RW_WRITE : `RW_READ};
      end
    end else if (bit_end) begin
      n.bitc = s.bitc + 4'h1;
      if (s.st == M_READ && s.bitc != 4'(`BIT_ACK)) n.sh = {s.sh[6:0], s.sda_s2};
      else if (s.bitc != 4'(`BIT_ACK)) n.sh = {s.sh[6:0], 1'b0};
      unique case (s.st)
        M_START: begin
          // Start bit sends no data; keep the address word whole
          n.sh   = s.sh;
          n.bitc = 4'h0;
          n.st   = (s.sh[0] == `RW_WRITE) ? M_DEV_W : M_DEV_R;
        end
        M_RSTART: begin
          n.bitc = 4'h0;
          n.st   = M_DEV_R;
          n.sh   = {DEV_TYPE, sel_w, `RW_READ};
        end
        M_STOP: begin
          n.st   = M_IDLE;
          n.busy = 1'b0;
        end
        M_READ: begin
          if (s.bitc == 4'(`BIT_ACK)) begin
            n.rdv  = 1'b1;
            n.rdd  = s.sh;
            n.left = s.left - 8'h01;
            n.bitc = 4'h0;
            // RULE4 nack then stop
            if (s.left == 8'h01) n.st = M_STOP;
          end
        end
        default: begin
          if (s.bitc == 4'(`BIT_ACK)) begin
            n.bitc = 4'h0;
            if (s.sda_s2 != `ACK_LOW) begin
              n.nack = 1'b1;
              n.st   = M_STOP;
            end else if (s.st == M_DEV_W) begin
              n.st = M_MADDR;
              n.sh = s.maddr[7:0];
            end else if (s.st == M_MADDR) begin
              n.st = M_RSTART;
            end else begin
              n.st = M_READ;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      // RULE10 lines held steady high
      s      <= '0;
      s.scl  <= 1'b1;
      s.oe_n <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign link.scl           = s.scl;
  assign link.host_sda_oe_n = s.oe_n;
  assign link.host_sda_o    = s.dout;
  assign rd_data            = s.rdd;
  assign rd_valid           = s.rdv;
  assign busy               = s.busy;
  assign nack               = s.nack;

endmodule : eeprom_read_master

`default_nettype wire

/* design/eeprom_read_end.sv */
// Read path of a two-wire serial EEPROM slave: addressing, random and sequential read
// How it works
// RULE1 - Dummy write loads address before random read
// RULE2 - Ack memory address; next start reads current
// RULE3 - First random byte comes from loaded address
// RULE4 - Nack plus stop returns to standby
// RULE5 - Master ack increments address, sends next byte
// RULE6 - Address wraps to zero past last location
// RULE7 - Master ends sequence with nack, stop
// RULE8 - Pulses under 50 ns are ignored
// RULE9 - Power-on guard blocks transfers until lines idle
// RULE10 - Master keeps lines steady during power switching
// RULE11 - Counter holds last accessed address plus one
// RULE12 - Data bytes shifted out MSB first
// RULE13 - No ack nor stop: release line
// RULE14 - Address word: type, select, direction bit
// RULE15 - Counter 8 or 9 bits, wraps modulo
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"

module eeprom_read_end
  import eeprom_pkg::*;
#(
  parameter int         ADDR_W   = 8,
  parameter logic [3:0] DEV_TYPE = 4'h5  // Arbitrary type code
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  eeprom_link_if.device          link,
  input  wire logic [2:0]        chip_select_strap_pins,
  input  wire logic              load_en,
  input  wire logic [ADDR_W-1:0] load_addr,
  input  wire logic [7:0]        load_data,
  output logic                   busy,
  output logic                   ready
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W != 8 && ADDR_W != 9) begin : g_bad_w
    $error("ADDR_W must be 8 or 9");
  end

  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [8:0] ADDR_MASK = 9'(DEPTH - 1);

  dev_regs_t   s;
  dev_regs_t   n;
  logic [7:0]  mem [0:DEPTH-1];
  logic        scl_chg;
  logic        sda_chg;
  logic        rise;
  logic        fall;
  logic        start_c;
  logic        stop_c;
  logic [7:0]  in_byte;
  logic [7:0]  rd_byte;
  logic        sel_ok;
  logic [8:0]  addr_inc;

  // ---------------------------------------------------------------
  // Array contents
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (ce && load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  assign rd_byte  = mem[s.addr[ADDR_W-1:0]];
  assign in_byte  = {s.sh[6:0], s.sda_f};
  // RULE15 modulo array size
  assign addr_inc = (s.addr + 9'h001) & ADDR_MASK;

  always_comb begin
    n        = s;
    scl_chg  = 1'b0;
    sda_chg  = 1'b0;
    // ---------------------------------------------------------------
    // Synchronisers
    // ---------------------------------------------------------------
    n.scl_s1 = link.scl;
    n.scl_s2 = s.scl_s1;
    n.sda_s1 = link.sda;
    n.sda_s2 = s.sda_s1;
    n.sel_s1 = chip_select_strap_pins;
    n.sel_s2 = s.sel_s1;
    // ---------------------------------------------------------------
    // Glitch filters
    // ---------------------------------------------------------------
    // RULE8 level must persist
    if (s.scl_s2 != s.scl_f) begin
      n.scl_cnt = s.scl_cnt + 4'h1;
      if (s.scl_cnt == 4'(`GLITCH_CYC)) begin
        scl_chg   = 1'b1;
        n.scl_f   = s.scl_s2;
        n.scl_cnt = 4'h0;
      end
    end else begin
      n.scl_cnt = 4'h0;
    end
    // RULE8 same on data
    if (s.sda_s2 != s.sda_f) begin
      n.sda_cnt = s.sda_cnt + 4'h1;
      if (s.sda_cnt == 4'(`GLITCH_CYC)) begin
        sda_chg   = 1'b1;
        n.sda_f   = s.sda_s2;
        n.sda_cnt = 4'h0;
      end
    end else begin
      n.sda_cnt = 4'h0;
    end
    rise    = scl_chg & s.scl_s2;
    fall    = scl_chg & ~s.scl_s2;
    start_c = sda_chg & ~s.sda_s2 & s.scl_f & ~scl_chg;
    stop_c  = sda_chg & s.sda_s2 & s.scl_f & ~scl_chg;
    // ---------------------------------------------------------------
    // Power-on guard
    // ---------------------------------------------------------------
    // RULE9 idle lines required
    if (!s.por_done) begin
      if (s.scl_f && s.sda_f) begin
        n.por_cnt = s.por_cnt + 8'h01;
        if (s.por_cnt == 8'(`POR_IDLE_CYC - 1)) n.por_done = 1'b1;
      end else begin
        n.por_cnt = 8'h00;
      end
    end
    // RULE14 type and select compare
    sel_ok = (in_byte[7:4] == DEV_TYPE) && (in_byte[3:2] == s.sel_s2[2:1]) &&
             ((ADDR_W == 9) || (in_byte[1] == s.sel_s2[0]));
    // ---------------------------------------------------------------
    // Transfer sequencer
    // ---------------------------------------------------------------
    if (stop_c) begin
      // RULE4 stop returns to standby
      n.st   = D_IDLE;
      n.oe_n = 1'b1;
    end else if (start_c && s.por_done) begin
      // RULE2 every start after the power-on guard has passed begins addressing
      n.st   = D_DEVADDR;
      n.cnt  = 4'h0;
      n.oe_n = 1'b1;
    end else begin
      unique case (s.st)
        D_IDLE, D_WAIT: begin
          n.oe_n = 1'b1;
        end
        D_DEVADDR: begin
          if (rise) begin
            n.sh  = in_byte;
            n.cnt = s.cnt + 4'h1;
            if (s.cnt == 4'(`BYTE_MSB)) begin
              n.rw   = in_byte[0];
              n.a8_p = in_byte[1] & (ADDR_W == 9);
              n.st   = sel_ok ? D_ACKDA : D_WAIT;
            end
          end
        end
        D_ACKDA: begin
          if (fall && s.cnt == 4'(`BIT_ACK)) begin
            n.oe_n = `ACK_LOW;
            n.cnt  = 4'h0;
          end else if (fall && s.rw == `RW_READ) begin
            // RULE11 read from counter
            // RULE3 loaded address first
            n.sh   = rd_byte;
            n.oe_n = rd_byte[`BYTE_MSB];
            n.st   = D_TX;
          end else if (fall) begin
            n.oe_n = 1'b1;
            n.st   = D_MEMADDR;
          end
        end
        D_MEMADDR: begin
          if (rise) begin
            n.sh  = in_byte;
            n.cnt = s.cnt + 4'h1;
            if (s.cnt == 4'(`BYTE_MSB)) begin
              // RULE1 dummy write sets address
              n.addr = {s.a8_p, in_byte};
              n.st   = D_ACKMA;
            end
          end
        end
        D_ACKMA: begin
          // RULE2 ack then await start
          if (fall && s.cnt == 4'(`BIT_ACK)) begin
            n.oe_n = `ACK_LOW;
            n.cnt  = 4'h0;
          end else if (fall) begin
            n.oe_n = 1'b1;
            n.st   = D_WAIT;
          end
        end
        D_TX: begin
          if (rise) begin
            // RULE12 shift out MSB first
            n.sh  = {s.sh[6:0], 1'b0};
            n.cnt = s.cnt + 4'h1;
            // RULE11 last accessed plus one
            // RULE6 wrap to zero
            if (s.cnt == 4'(`BYTE_MSB)) n.addr = addr_inc;
          end else if (fall && s.cnt == 4'(`BIT_ACK)) begin
            n.oe_n = 1'b1;
            n.st   = D_RXACK;
          end else if (fall) begin
            n.oe_n = s.sh[`BYTE_MSB];
          end
        end
        D_RXACK: begin
          if (rise && s.sda_f == `ACK_LOW) begin
            // RULE5 ack fetches next byte
            n.sh  = rd_byte;
            n.cnt = 4'h0;
            n.st  = D_TX;
          end else if (rise) begin
            // RULE13 release and stay silent
            n.st   = D_WAIT;
            n.oe_n = 1'b1;
          end
        end
      endcase
    end
    n.dout = 1'b0;
    n.busy = (n.st != D_IDLE) && (n.st != D_WAIT);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s        <= '0;
      s.scl_s1 <= 1'b1;
      s.scl_s2 <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
      s.scl_f  <= 1'b1;
      s.sda_f  <= 1'b1;
      s.oe_n   <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign link.dev_sda_oe_n = s.oe_n;
  assign link.dev_sda_o    = s.dout;
  assign busy              = s.busy;
  assign ready             = s.por_done;

endmodule : eeprom_read_end

`default_nettype wire

/* testbench/eeprom_link_checker.sv */
// Concurrent checks on the two-wire link between master and read end
`timescale 1ns/1ps
`default_nettype none

module eeprom_link_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ---------------------------------------------------------------
  // Line driving
  // ---------------------------------------------------------------
  property p_dev_low;
    !dev_sda_oe_n |-> !dev_sda_o;
  endproperty
  a_dev_low: assert property (p_dev_low)
    else $error("device drives sda high");

  property p_host_low;
    !host_sda_oe_n |-> !host_sda_o;
  endproperty
  a_host_low: assert property (p_host_low)
    else $error("master drives sda high");

  property p_dev_change_low;
    $changed(dev_sda_oe_n) |-> !scl;
  endproperty
  a_dev_change_low: assert property (p_dev_change_low)
    else $error("device sda changed with scl high");

  property p_dev_hold;
    $fell(scl) |-> $stable(dev_sda_oe_n) [*2];
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("device sda changed right at scl fall");

  property p_ack_reach;
    $fell(dev_sda_oe_n) |-> ##[1:20] (scl && !dev_sda_oe_n);
  endproperty
  a_ack_reach: assert property (p_ack_reach)
    else $error("device low level not held into scl high");

  // ---------------------------------------------------------------
  // Conditions and clock shape
  // ---------------------------------------------------------------
  property p_start_free;
    (scl && $past(scl) && $fell(sda)) |-> dev_sda_oe_n;
  endproperty
  a_start_free: assert property (p_start_free)
    else $error("device drives sda at start");

  property p_stop_release;
    (scl && $past(scl) && $rose(sda)) |-> dev_sda_oe_n [*8];
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("device drives sda after stop");

  property p_scl_high;
    $rose(scl) |-> scl [*8];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("scl high phase too short");

  property p_scl_low;
    $fell(scl) |-> !scl [*8];
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("scl low phase too short");

  property p_no_fight;
    scl |-> (host_sda_oe_n || dev_sda_oe_n);
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive sda with scl high");
endmodule : eeprom_link_checker

`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench joining master and read end over one link
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import eeprom_pkg::*;

  typedef struct packed {
    logic       rnd;
    logic [2:0] sel;
    logic [8:0] addr;
    logic [7:0] n;
    logic       exp_nack;
  } row_t;

  logic       ref_clk, resetn, go, random, rd_valid, busy, nack, d_busy, ready, load_en;
  logic [2:0] chip_sel;
  logic [8:0] mem_addr;
  logic [7:0] nbytes, rd_data, load_addr, load_data;
  int         fails, total_checks, ptr;

  row_t rows [8] = '{
    '{1'b1, 3'h2, 9'h010, 8'h01, 1'b0},
    '{1'b0, 3'h2, 9'h000, 8'h02, 1'b0},
    '{1'b1, 3'h2, 9'h0FE, 8'h04, 1'b0},
    '{1'b0, 3'h2, 9'h000, 8'h01, 1'b0},
    '{1'b1, 3'h5, 9'h040, 8'h01, 1'b1},
    '{1'b0, 3'h3, 9'h000, 8'h01, 1'b1},
    '{1'b0, 3'h2, 9'h000, 8'h01, 1'b0},
    '{1'b1, 3'h2, 9'h080, 8'h03, 1'b0}
  };

  eeprom_link_if i_link ();

  eeprom_read_master i_eeprom_read_master (
    .ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .link(i_link.host), .go(go),
    .random(random), .chip_sel(chip_sel), .mem_addr(mem_addr), .nbytes(nbytes),
    .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .nack(nack)
  );

  eeprom_read_end i_eeprom_read_end (
    .ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .link(i_link.device),
    .chip_select_strap_pins(3'h2), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .busy(d_busy), .ready(ready)
  );

  eeprom_link_checker i_eeprom_link_checker (
    .ref_clk(ref_clk), .resetn(resetn), .scl(i_link.scl), .sda(i_link.sda),
    .host_sda_o(i_link.host_sda_o), .host_sda_oe_n(i_link.host_sda_oe_n),
    .dev_sda_o(i_link.dev_sda_o), .dev_sda_oe_n(i_link.dev_sda_oe_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'hA5;
  endfunction : pat

  task automatic final_report();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic chk_idle();
    check({4'h0, i_link.scl, busy, d_busy, ready, nack | rd_valid}, 9'h010);
  endtask : chk_idle

  task automatic run_xfer(input row_t r);
    int got;
    int k;
    got = 0;
    k = 0;
    while (ready !== 1'b1 && k < 100) begin
      @(negedge ref_clk);
      k++;
    end
    check({8'h00, ready}, 9'h001);
    if (ready !== 1'b1)
      final_report();
    @(negedge ref_clk);
    go = 1'b1;
    random = r.rnd;
    chip_sel = r.sel;
    mem_addr = r.addr;
    nbytes = r.n;
    @(negedge ref_clk);
    go = 1'b0;
    if (r.rnd && !r.exp_nack)
      ptr = r.addr;
    for (k = 0; k < 20000 && busy !== 1'b0; k++) begin
      @(negedge ref_clk);
      if (rd_valid === 1'b1) begin
        check({1'b0, rd_data}, {1'b0, pat(ptr[7:0])});
        ptr = (ptr + 1) % 256;
        got++;
      end
    end
    if (k >= 20000) begin
      fails++;
      final_report();
    end
    check(9'(got), {1'b0, r.exp_nack ? 8'h00 : r.n});
    check({8'h00, nack}, {8'h00, r.exp_nack});
  endtask : run_xfer

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    fails = 0;
    total_checks = 0;
    ptr = 0;
    resetn = 1'b0;
    go = 1'b0;
    random = 1'b0;
    chip_sel = 3'h0;
    mem_addr = 9'h000;
    nbytes = 8'h01;
    load_en = 1'b0;
    load_addr = 8'h00;
    load_data = 8'h00;
    repeat (2) @(negedge ref_clk);
    chk_idle();
    resetn = 1'b1;
    for (int a = 0; a < 256; a++) begin
      load_en = 1'b1;
      load_addr = a[7:0];
      load_data = pat(a[7:0]);
      @(negedge ref_clk);
    end
    load_en = 1'b0;
    foreach (rows[i])
      run_xfer(rows[i]);
    // Reset in mid transfer
    go = 1'b1;
    random = 1'b1;
    chip_sel = 3'h2;
    mem_addr = 9'h030;
    @(negedge ref_clk);
    go = 1'b0;
    repeat (200) @(negedge ref_clk);
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk_idle();
    resetn = 1'b1;
    // Start before the power-on guard has passed
    go = 1'b1;
    random = 1'b0;
    nbytes = 8'h01;
    @(negedge ref_clk);
    go = 1'b0;
    for (int w = 0; w < 2000 && busy !== 1'b0; w++)
      @(negedge ref_clk);
    check({7'h00, busy, nack}, 9'h001);
    if (busy !== 1'b0)
      final_report();
    ptr = 0;
    run_xfer(row_t'{1'b0, 3'h2, 9'h000, 8'h02, 1'b0});
    final_report();
  end
endmodule : testbench

`default_nettype wire
